// *** rtl/sram_ctl_defs.svh ***
// Constants for the synchronous burst SRAM control block
`ifndef SRAM_CTL_DEFS_SVH
`define SRAM_CTL_DEFS_SVH

`define SRAM_ADDR_W 8
`define SRAM_LANES 4
`define SRAM_LANE_W 9
`define SRAM_BURST_W 2

`define REG_CTRL_OFS 4'h0
`define REG_STATUS_OFS 4'h4
`define REG_OFS_MSB 3
`define CTRL_STANDBY_BIT 0
`define CTRL_RESET_VAL 1'b0

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// *** rtl/sram_ctl_pkg.sv ***
// Types shared by the synchronous burst SRAM control block
package sram_ctl_pkg;

  typedef enum logic [3:0] {
    OP_IDLE = 4'h1,
    OP_READ = 4'h2,
    OP_WRITE = 4'h4,
    OP_SLEEP = 4'h8
  } op_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage

// *** rtl/burst_counter.sv ***
// Two-bit burst address counter with linear or interleaved order
`timescale 1ns/100ps
`include "sram_ctl_defs.svh"
module burst_counter
  import sram_ctl_pkg::*;
#(
  parameter int BW = `SRAM_BURST_W
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Control
  input wire logic load_in,
  input wire logic step_in,
  input wire logic interleave_in,
  input wire logic [BW-1:0] preset_in,
  // Burst address for this cycle and the previous one
  output logic [BW-1:0] now_out,
  output logic [BW-1:0] cur_out
);

  typedef struct packed {
    logic [BW-1:0] start;
    logic [BW-1:0] count;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  function automatic logic [BW-1:0] seq(input logic [BW-1:0] s, input logic [BW-1:0] c,
                                        input logic il);
    seq = il ? (s ^ c) : BW'(s + c);
  endfunction

  always_comb begin
    state_next = state_reg;
    if (load_in) begin
      state_next.start = preset_in;
      state_next.count = '0;
    end else if (step_in) begin
      // Count wraps modulo four, so the fourth step returns to the start
      state_next.count = BW'(state_reg.count + 1'b1);
    end
  end

  assign now_out = seq(state_next.start, state_next.count, interleave_in);
  assign cur_out = seq(state_reg.start, state_reg.count, interleave_in);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule // burst_counter

// *** rtl/lane_write_decode.sv ***
// Byte-lane write decode from the global and per-lane write controls
`timescale 1ns/100ps
`include "sram_ctl_defs.svh"
module lane_write_decode
  import sram_ctl_pkg::*;
#(
  parameter int LANES = `SRAM_LANES
) (
  // Write controls
  input wire logic all_lanes_write_n_in,
  input wire logic lane_write_gate_n_in,
  input wire logic [LANES-1:0] lane_write_n_in,
  // Decoded cycle
  output logic is_write_out,
  output logic [LANES-1:0] lane_mask_out
);

  always_comb begin
    if (!all_lanes_write_n_in) begin
      is_write_out = 1'b1;
      lane_mask_out = '1;
    end else if (!lane_write_gate_n_in) begin
      is_write_out = 1'b1;
      // Any mix of lanes, including none at all
      lane_mask_out = ~lane_write_n_in;
    end else begin
      is_write_out = 1'b0;
      lane_mask_out = '0;
    end
  end

endmodule // lane_write_decode

// *** rtl/sync_burst_sram_control.sv ***
// Synchronous burst SRAM core: cycle decode, burst counter, lanes, AXI4-Lite status
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "sram_ctl_defs.svh"
module sync_burst_sram_control
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int LANES = `SRAM_LANES,
  parameter int LANE_W = `SRAM_LANE_W
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Synchronous bus controls
  input wire logic chip_select_n_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic all_lanes_write_n_in,
  input wire logic lane_write_gate_n_in,
  input wire logic [LANES-1:0] lane_write_n_in,
  input wire logic out_enable_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  // Mode pins
  input wire logic burst_order_sel_n_in,
  input wire logic flow_through_sel_n_in,
  input wire logic sleep_req_in,
  // Data lanes, parity bit on top of each lane
  input wire logic [LANES*LANE_W-1:0] data_lane_in,
  output logic [LANES*LANE_W-1:0] data_lane_out,
  output logic [LANES-1:0] data_lane_oe_out,
  // Status
  output logic standby_out,
  // Register bus
  input wire axil_req_t axil_req_in,
  output axil_rsp_t axil_rsp_out
);

  localparam int BW = `SRAM_BURST_W;
  localparam int DW = LANES * LANE_W;

  typedef struct packed {
    logic [ADDR_W-1:BW] addr_hi;
    logic [DW-1:0] stage_data;
    logic stage_valid;
    logic [DW-1:0] out_data;
    logic out_drive;
    logic [LANES-1:0] out_oe;
    logic standby;
    op_t last_op;
    logic ctrl_standby;
    logic aw_got;
    logic [31:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    axil_rsp_t rsp;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  logic [LANE_W-1:0] mem [LANES][2**ADDR_W];

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  logic chip_on;
  logic sleeping;
  logic deselect;
  logic load_addr;
  logic force_read;
  logic cont;
  logic dec_write;
  logic [LANES-1:0] dec_mask;
  logic do_write;
  logic do_read;
  logic [LANES-1:0] wr_mask;
  logic [BW-1:0] burst_now;
  logic [BW-1:0] burst_cur;
  logic [ADDR_W-1:BW] hi_now;
  logic [ADDR_W-1:0] mem_addr;
  logic [DW-1:0] rd_word;

  assign chip_on = ~chip_select_n_in;
  // Pins float to pipelined and awake through the pads
  assign sleeping = sleep_req_in | state_reg.ctrl_standby;
  assign deselect = ~sleeping & ~chip_on & ~ctrl_addr_strobe_n_in;
  assign force_read = chip_on & ~proc_addr_strobe_n_in;
  assign load_addr = ~sleeping & chip_on
                     & (~proc_addr_strobe_n_in | ~ctrl_addr_strobe_n_in);
  assign cont = ~sleeping & ~deselect & ~load_addr;

  lane_write_decode #(
    .LANES(LANES)
  ) u_lane_dec (
    .all_lanes_write_n_in(all_lanes_write_n_in),
    .lane_write_gate_n_in(lane_write_gate_n_in),
    .lane_write_n_in(lane_write_n_in),
    .is_write_out(dec_write),
    .lane_mask_out(dec_mask)
  );

  assign do_write = (load_addr | cont) & dec_write & ~force_read;
  assign do_read = (load_addr | cont) & ~do_write;
  assign wr_mask = do_write ? dec_mask : '0;

  burst_counter #(
    .BW(BW)
  ) u_burst (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .load_in(load_addr),
    .step_in(cont & ~burst_advance_n_in),
    .interleave_in(burst_order_sel_n_in),
    .preset_in(addr_in[BW-1:0]),
    .now_out(burst_now),
    .cur_out(burst_cur)
  );

  assign hi_now = load_addr ? addr_in[ADDR_W-1:BW] : state_reg.addr_hi;
  assign mem_addr = {hi_now, burst_now};

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      rd_word[l*LANE_W +: LANE_W] = mem[l][mem_addr];
    end
  end

  // Writes land at the sampling edge, so a read right after sees them
  always_ff @(posedge mclk_in) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_mask[l]) begin
        mem[l][mem_addr] <= data_lane_in[l*LANE_W +: LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [`REG_OFS_MSB:0] wr_ofs;
  logic [`REG_OFS_MSB:0] rd_ofs;
  logic [31:0] status_word;

  always_comb begin
    state_next = state_reg;
    wr_ofs = state_reg.aw_addr[`REG_OFS_MSB:0];
    rd_ofs = axil_req_in.araddr[`REG_OFS_MSB:0];
    status_word = '0;
    status_word[3:0] = state_reg.last_op;
    status_word[5:4] = burst_cur;
    status_word[6] = state_reg.standby;
    status_word[7] = burst_order_sel_n_in;
    status_word[8] = flow_through_sel_n_in;

    state_next.addr_hi = hi_now;
    state_next.standby = sleeping;
    case ({sleeping, do_write, do_read})
      3'h4: state_next.last_op = OP_SLEEP;
      3'h2: state_next.last_op = OP_WRITE;
      3'h1: state_next.last_op = OP_READ;
      3'h0: state_next.last_op = OP_IDLE;
      default: state_next.last_op = OP_SLEEP;
    endcase

    // Deselects travel the same pipe as reads, so lanes turn off in step
    state_next.stage_data = rd_word;
    state_next.stage_valid = do_read;
    if (!flow_through_sel_n_in) begin
      state_next.out_data = rd_word;
      state_next.out_drive = do_read;
    end else begin
      state_next.out_data = state_reg.stage_data;
      state_next.out_drive = state_reg.stage_valid;
    end
    // Output enable is sampled, so it acts one edge late
    state_next.out_oe = {LANES{state_next.out_drive & ~out_enable_n_in}};

    // Write channel, address and data in either order
    if (state_reg.rsp.awready && axil_req_in.awvalid) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = axil_req_in.awaddr;
    end
    if (state_reg.rsp.wready && axil_req_in.wvalid) begin
      state_next.w_got = 1'b1;
      state_next.w_data = axil_req_in.wdata;
      state_next.w_strb = axil_req_in.wstrb;
    end
    if (state_reg.rsp.bvalid && axil_req_in.bready) begin
      state_next.rsp.bvalid = 1'b0;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.rsp.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.rsp.bvalid = 1'b1;
      state_next.rsp.bresp = `AXI_RESP_OKAY;
      if (wr_ofs == `REG_CTRL_OFS) begin
        if (state_reg.w_strb[0]) begin
          state_next.ctrl_standby = state_reg.w_data[`CTRL_STANDBY_BIT];
        end
      end else if (wr_ofs != `REG_STATUS_OFS) begin
        state_next.rsp.bresp = `AXI_RESP_SLVERR;
      end
    end
    state_next.rsp.awready = ~state_next.aw_got & ~state_next.rsp.bvalid;
    state_next.rsp.wready = ~state_next.w_got & ~state_next.rsp.bvalid;

    // Read channel, one word at a time
    if (state_reg.rsp.rvalid && axil_req_in.rready) begin
      state_next.rsp.rvalid = 1'b0;
    end
    if (state_reg.rsp.arready && axil_req_in.arvalid) begin
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rresp = `AXI_RESP_OKAY;
      state_next.rsp.rdata = '0;
      if (rd_ofs == `REG_CTRL_OFS) begin
        state_next.rsp.rdata[`CTRL_STANDBY_BIT] = state_reg.ctrl_standby;
      end else if (rd_ofs == `REG_STATUS_OFS) begin
        state_next.rsp.rdata = status_word;
      end else begin
        state_next.rsp.rresp = `AXI_RESP_SLVERR;
      end
    end
    state_next.rsp.arready = ~state_next.rsp.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= '0;
      state_reg.last_op <= OP_IDLE;
      state_reg.ctrl_standby <= `CTRL_RESET_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign data_lane_out = state_reg.out_data;
  assign data_lane_oe_out = state_reg.out_oe;
  assign standby_out = state_reg.standby;
  assign axil_rsp_out = state_reg.rsp;

endmodule // sync_burst_sram_control

// *** bench/sram_bus_model.sv ***
// Behavioural bus master for the synchronous burst SRAM pins
`timescale 1ns/100ps
module sram_bus_model (
  // Clock
  input wire logic mclk_in,
  // {select, proc strobe, ctrl strobe, advance, global wr, gate, lanes[3:0]}, active low
  output logic [9:0] ctrl_out,
  output logic [7:0] addr_out,
  output logic [35:0] data_out
);
  initial begin
    ctrl_out = 10'h37F;
    addr_out = 8'h00;
    data_out = 36'h0;
  end
  // Unless the global write or the gate is low the data toggles each cycle, so stale data never looks valid
  task automatic cyc(input logic [9:0] c, input logic [7:0] a, input logic [35:0] d);
    ctrl_out <= c;
    addr_out <= a;
    data_out <= (!c[5] || !c[4]) ? d : ~data_out;
    @(posedge mclk_in);
  endtask
endmodule // sram_bus_model

// *** bench/sram_ctl_props.sv ***
// Checker of output-driver timing for the burst SRAM control block
`timescale 1ns/100ps
`include "sram_ctl_defs.svh"
module sram_ctl_props
  import sram_ctl_pkg::*;
#(
  parameter int LANES = `SRAM_LANES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Watched pins
  input wire logic chip_select_n_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic all_lanes_write_n_in,
  input wire logic lane_write_gate_n_in,
  input wire logic out_enable_n_in,
  input wire logic flow_through_sel_n_in,
  input wire logic sleep_req_in,
  input wire logic [LANES-1:0] data_lane_oe_out,
  input wire logic standby_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  logic ok, rd, wr, ds, ft;
  assign ok = !out_enable_n_in && !standby_out && !sleep_req_in;
  assign rd = ok && !chip_select_n_in && !proc_addr_strobe_n_in;
  assign wr = !chip_select_n_in && proc_addr_strobe_n_in && !ctrl_addr_strobe_n_in
    && !(all_lanes_write_n_in && lane_write_gate_n_in);
  assign ds = chip_select_n_in && !ctrl_addr_strobe_n_in;
  assign ft = !flow_through_sel_n_in;
  // ----
  // Driver timing
  // ----
  // Pipelined read: drivers come on only after the second edge
  sequence s_pipe_rd; rd && !ft ##1 ok ##1 ok; endsequence
  sequence s_nap; sleep_req_in [*3]; endsequence
  property p_flow_rd; rd && ft ##1 ok |-> data_lane_oe_out == '1; endproperty
  property p_pipe_rd; s_pipe_rd |-> data_lane_oe_out == '1; endproperty
  property p_pipe_late; ds && !ft ##1 rd |=> data_lane_oe_out == '0; endproperty
  property p_wr_flow; wr && ft |=> data_lane_oe_out == '0; endproperty
  property p_wr_pipe; wr && !ft |-> ##2 data_lane_oe_out == '0; endproperty
  property p_desel; ds && ft |=> data_lane_oe_out == '0; endproperty
  property p_oe_gate; out_enable_n_in |=> data_lane_oe_out == '0; endproperty
  property p_sleep; s_nap |=> standby_out && data_lane_oe_out == '0; endproperty
  a_flow_rd: assert property (p_flow_rd) else $error("flow read not driven");
  a_pipe_rd: assert property (p_pipe_rd) else $error("pipe read not driven");
  a_pipe_late: assert property (p_pipe_late) else $error("pipe read too early");
  a_wr_flow: assert property (p_wr_flow) else $error("driven in write");
  a_wr_pipe: assert property (p_wr_pipe) else $error("driven in write");
  a_desel: assert property (p_desel) else $error("driven after deselect");
  a_oe_gate: assert property (p_oe_gate) else $error("driven with enable off");
  a_sleep: assert property (p_sleep) else $error("active in sleep");
endmodule // sram_ctl_props
bind sync_burst_sram_control sram_ctl_props #(.LANES(LANES)) props_u (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .chip_select_n_in(chip_select_n_in),
  .proc_addr_strobe_n_in(proc_addr_strobe_n_in),
  .ctrl_addr_strobe_n_in(ctrl_addr_strobe_n_in),
  .all_lanes_write_n_in(all_lanes_write_n_in), .lane_write_gate_n_in(lane_write_gate_n_in),
  .out_enable_n_in(out_enable_n_in), .flow_through_sel_n_in(flow_through_sel_n_in),
  .sleep_req_in(sleep_req_in), .data_lane_oe_out(data_lane_oe_out),
  .standby_out(standby_out));

// *** bench/sync_burst_sram_control_tb_top.sv ***
// Testbench: bursts, lane writes, sleep and register access
`timescale 1ns/100ps
module sync_burst_sram_control_tb_top;
  import sram_ctl_pkg::*;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic oe_n = 1'b0;
  logic ord_n = 1'b0;
  logic ft_n = 1'b1;
  logic sleep = 1'b0;
  logic [9:0] ctl;
  logic [7:0] adr;
  logic [35:0] wd, rdat;
  logic [3:0] loe;
  logic sb;
  axil_req_t rq = '0;
  axil_rsp_t rs;
  logic [35:0] mem [256];
  int error_cnt = 0;
  int cmp_count = 0;
  int ticks = 0;
  initial forever #4 mclk_in = ~mclk_in;
  sync_burst_sram_control dut_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .chip_select_n_in(ctl[9]), .proc_addr_strobe_n_in(ctl[8]),
    .ctrl_addr_strobe_n_in(ctl[7]), .burst_advance_n_in(ctl[6]),
    .all_lanes_write_n_in(ctl[5]), .lane_write_gate_n_in(ctl[4]),
    .lane_write_n_in(ctl[3:0]), .out_enable_n_in(oe_n), .addr_in(adr),
    .burst_order_sel_n_in(ord_n), .flow_through_sel_n_in(ft_n), .sleep_req_in(sleep),
    .data_lane_in(wd), .data_lane_out(rdat), .data_lane_oe_out(loe),
    .standby_out(sb), .axil_req_in(rq), .axil_rsp_out(rs));
  sram_bus_model bus_u (.mclk_in(mclk_in), .ctrl_out(ctl), .addr_out(adr), .data_out(wd));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] c, input logic [7:0] a, input logic [35:0] d);
    bus_u.cyc(c, a, d);
    for (int l = 0; l < 4; l++)
      if (!c[5] || (!c[4] && !c[l])) mem[a][l*9+:9] = d[l*9+:9];
  endtask
  // Burst read; md 0 linear, 1 interleaved, 2 held; first dk reads have drivers off
  task automatic rd(input logic [9:0] f, input logic [7:0] a, input int n,
                    input logic [9:0] nx, input int md, input int dk);
    int lat;
    int k;
    logic [7:0] e;
    lat = ft_n ? 2 : 1;
    for (int i = 0; i < n + lat; i++) begin
      oe_n <= (i - lat + 1 < dk);
      bus_u.cyc(i == 0 ? f : (i < n ? nx : 10'h37F), a, 36'h0);
      k = i - lat;
      e = {a[7:2], md == 0 ? a[1:0] + 2'(k) : (md == 1 ? a[1:0] ^ 2'(k) : a[1:0])};
      if (k >= 0 && k < dk) chk({32'h0, loe}, 36'h0);
      if (k >= dk) chk({32'h0, loe}, 36'hF);
      if (k >= dk) chk(rdat, mem[e]);
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge mclk_in);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1);
    rq.bready <= 1'b0;
    chk({34'h0, rs.bresp}, {34'h0, r});
  endtask
  task automatic axr(input logic [31:0] a, input logic [1:0] r, output logic [31:0] d);
    @(posedge mclk_in);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (rs.arready) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1);
    rq.rready <= 1'b0;
    d = rs.rdata;
    chk({34'h0, rs.rresp}, {34'h0, r});
  endtask
  task automatic t_burst(input logic fl);
    ft_n <= fl;
    ord_n <= 1'b0;
    for (int i = 0; i < 8; i++) wr(10'h15F, 8'h40 + 8'(i), 36'(36'h9ABCD1234 * 36'(i + 3)));
    rd(10'h0DF, 8'h46, 6, 10'h1BF, 0, 0);
    ord_n <= 1'b1;
    rd(10'h17F, 8'h45, 6, 10'h1BF, 1, 0);
    rd(10'h0DF, 8'h47, 3, 10'h1FF, 2, 0);
    rd(10'h0DF, 8'h41, 4, 10'h1BF, 1, 2);
    $display("burst test done, flow pin %0d", fl);
  endtask
  task automatic t_lanes;
    logic [3:0] pat [4] = '{4'hA, 4'hF, 4'h6, 4'h0};
    ord_n <= 1'b0;
    for (int i = 0; i < 4; i++) wr(10'h15F, 8'h50 + 8'(i), 36'h0);
    for (int i = 0; i < 4; i++) wr({6'h16, pat[i]}, 8'h50 + 8'(i), 36'hFEDCBA987);
    rd(10'h0DF, 8'h50, 4, 10'h1BF, 0, 0);
    $display("lane test done");
  endtask
  task automatic t_sleep_regs;
    logic [31:0] d;
    sleep <= 1'b1;
    repeat (4) bus_u.cyc(10'h0DF, 8'h40, 36'h0);
    chk({35'h0, sb}, 36'h1);
    chk({32'h0, loe}, 36'h0);
    sleep <= 1'b0;
    repeat (3) bus_u.cyc(10'h37F, 8'h00, 36'h0);
    chk({35'h0, sb}, 36'h0);
    axr(32'h4, 2'h0, d);
    chk({33'h0, d[8:6]}, {33'h0, ft_n, ord_n, 1'b0});
    axw(32'h0, 32'h1, 2'h0);
    repeat (2) bus_u.cyc(10'h37F, 8'h00, 36'h0);
    chk({35'h0, sb}, 36'h1);
    axr(32'h0, 2'h0, d);
    chk({35'h0, d[0]}, 36'h1);
    axw(32'h0, 32'h0, 2'h0);
    axw(32'h8, 32'h1, 2'h2);
    axr(32'h8, 2'h2, d);
    $display("sleep and register test done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    t_burst(1'b1);
    t_burst(1'b0);
    t_lanes;
    t_sleep_regs;
    end_sim;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge mclk_in) begin
    ticks++;
    if (ticks == 5000) begin
      error_cnt++;
      end_sim;
    end
  end
endmodule // sync_burst_sram_control_tb_top
